// file: hdl/sdfs_supervisor.sv
// fault supervisor and serial diagnostic status of one chain node
// ----------------------------------------------------------------
// Notes on behaviour
// - node answers only at its own chain position, 1 to 31.
// - serial chain input is retimed and passed to the chain output.
// - response and detail bytes refresh every cycle without any request.
// - link loss never changes the safety channel state.
// - internal error switches both safety channels off within a few cycles.
// - non-latching error clears when cause gone and ack falls or guard opens.
// - output channel errors clear only on a guard closing with no warning present.
// - two output faults or shorted channels lock until power removed.
// - warning drops diagnostic ok while channels stay enabled.
// - warning bits follow their causes, no acknowledge needed.
// - warning held 30 minutes switches channels off and lights red.
// - detail bytes show the cause behind each warning or error flag.
// - every status and request bit is active high.
// - response bits 0,1,4,5: outputs on, actuator, guards, door.
// - response bit 6 warning, bit 7 error with channels off.
// - warning detail bits 0-3 faults, 5 internal, 6 link error.
// - error detail bits 0-3 faults, 4 bad actuator, 5 internal.
// ----------------------------------------------------------------
`timescale 1ns/100ps
`include "sdfs_cfg.svh"
module sdfs_supervisor import sdfs_pkg::*; #(
  parameter logic [`SDFS_TIMER_W-1:0] WARN_CYCLES = `SDFS_TIMER_W'(`SDFS_WARN_CYCLES)
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [4:0] node_position,
  input wire logic guard_input_a,
  input wire logic guard_input_b,
  input wire logic actuator_present,
  input wire logic door_present,
  input wire logic fault_channel_a,
  input wire logic fault_channel_b,
  input wire logic cross_short,
  input wire logic over_temp,
  input wire logic internal_fault,
  input wire logic actuator_invalid,
  input wire logic channels_shorted,
  input wire logic serial_diag_chain_in,
  input wire logic req_valid,
  input wire logic [4:0] req_node,
  input wire sdfs_byte_t diag_request_byte,
  input wire logic link_fail,
  output logic serial_diag_chain_out,
  output logic safety_channel_a,
  output logic safety_channel_b,
  output logic diag_ok,
  output logic fault_led,
  output sdfs_byte_t status_response_byte,
  output sdfs_byte_t warning_detail_byte,
  output sdfs_byte_t error_detail_byte
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // rising edge of a level against its previous value
  function automatic logic rose_of(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  // saturating two-bit add
  function automatic logic [1:0] sat_add(input logic [1:0] a, input logic [1:0] b);
    logic [2:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[2] ? 2'h3 : s[1:0];
  endfunction

  logic [`SDFS_PIN_W-1:0] pin_meta_r;
  logic [`SDFS_PIN_W-1:0] pin_s_r;
  logic [`SDFS_PIN_W-1:0] pin_prev_r;
  logic closed_prev_r;
  logic ack_prev_r;
  logic err_int_r;
  logic err_act_r;
  logic [3:0] err_out_r;
  logic lock_r;
  logic [1:0] out_fault_cnt_r;
  logic [1:0] out_fault_cnt_nxt;
  sdfs_state_e state_r;
  sdfs_state_e state_nxt;
  logic guard_closed;
  logic guard_opened;
  logic guard_reclosed;
  logic [3:0] warn_cause;
  logic warn_any;
  logic warn_expired;
  logic node_ok;
  logic req_take;
  logic ack_fall;
  logic err_any;
  logic lock_set;
  logic chan_on;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (WARN_CYCLES == '0) begin
      $error("warning shutdown time must be at least one cycle");
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // two flops on every pin; the first stage feeds only the second
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= `SDFS_PINS_RST;
      pin_s_r <= `SDFS_PINS_RST;
    end else begin
      pin_meta_r <= {serial_diag_chain_in, channels_shorted, actuator_invalid,
                     internal_fault, over_temp, cross_short, fault_channel_b,
                     fault_channel_a, door_present, actuator_present,
                     guard_input_b, guard_input_a};
      pin_s_r <= pin_meta_r;
    end
  end

  // previous synchronised values for edge detection
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_r <= `SDFS_PINS_RST;
      closed_prev_r <= 1'b0;
    end else begin
      pin_prev_r <= pin_s_r;
      closed_prev_r <= guard_closed;
    end
  end

  // ----------------------------------------------------------------
  // chain forwarding
  // ----------------------------------------------------------------
  // downstream traffic retimed toward the gateway
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      serial_diag_chain_out <= 1'b0;
    end else begin
      serial_diag_chain_out <= pin_s_r[`SDFS_PIN_CHAIN];
    end
  end

  // ----------------------------------------------------------------
  // guard and cause decoding
  // ----------------------------------------------------------------
  assign guard_closed = pin_s_r[`SDFS_PIN_GA] & pin_s_r[`SDFS_PIN_GB] & pin_s_r[`SDFS_PIN_ACT];
  assign guard_opened = closed_prev_r & ~guard_closed;
  assign guard_reclosed = rose_of(guard_closed, closed_prev_r);
  assign warn_cause = {pin_s_r[`SDFS_PIN_TEMP], pin_s_r[`SDFS_PIN_CROSS],
                       pin_s_r[`SDFS_PIN_FB], pin_s_r[`SDFS_PIN_FA]};
  assign warn_any = |warn_cause;

  // ----------------------------------------------------------------
  // request intake
  // ----------------------------------------------------------------
  // only a valid position in the chain takes its own request byte
  assign node_ok = (node_position >= `SDFS_MIN_NODE) && (node_position <= `SDFS_MAX_NODES);
  assign req_take = req_valid & ~link_fail & node_ok & (req_node == node_position);
  assign ack_fall = req_take & ack_prev_r & ~diag_request_byte[`SDFS_REQ_ACK];

  // stored ack bit, one acknowledge per falling transition
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_prev_r <= 1'b0;
    end else if (req_take) begin
      ack_prev_r <= diag_request_byte[`SDFS_REQ_ACK];
    end
  end

  // ----------------------------------------------------------------
  // warning persistence
  // ----------------------------------------------------------------
  sdfs_warn_timer #(
    .CW(`SDFS_TIMER_W),
    .LIMIT(WARN_CYCLES)
  ) u_warn_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(warn_any),
    .expired(warn_expired)
  );

  // ----------------------------------------------------------------
  // error latches
  // ----------------------------------------------------------------
  // non-latching errors: cause present holds them, so a set wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      err_int_r <= 1'b0;
    end else if (pin_s_r[`SDFS_PIN_INT]) begin
      err_int_r <= 1'b1;
    end else if (ack_fall | guard_opened) begin
      err_int_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      err_act_r <= 1'b0;
    end else if (pin_s_r[`SDFS_PIN_BADACT]) begin
      err_act_r <= 1'b1;
    end else if (ack_fall | guard_opened) begin
      err_act_r <= 1'b0;
    end
  end

  // output errors: set by an expired warning, cleared at a guard closing with no warning
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      err_out_r <= 4'h0;
    end else begin
      err_out_r <= ((guard_reclosed && !warn_any) ? 4'h0 : err_out_r)
                   | (warn_expired ? warn_cause : 4'h0);
    end
  end

  // output fault events counted toward lockout
  assign out_fault_cnt_nxt = sat_add(out_fault_cnt_r,
    {1'b0, rose_of(pin_s_r[`SDFS_PIN_FA], pin_prev_r[`SDFS_PIN_FA])}
    + {1'b0, rose_of(pin_s_r[`SDFS_PIN_FB], pin_prev_r[`SDFS_PIN_FB])});
  assign lock_set = pin_s_r[`SDFS_PIN_SHORT] | (out_fault_cnt_nxt >= 2'h2);

  // lockout: only a power cycle reset releases it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_fault_cnt_r <= `SDFS_CNT_RST;
      lock_r <= 1'b0;
    end else begin
      out_fault_cnt_r <= out_fault_cnt_nxt;
      lock_r <= lock_r | lock_set;
    end
  end

  assign err_any = err_int_r | err_act_r | (|err_out_r);

  // ----------------------------------------------------------------
  // supervisor state
  // ----------------------------------------------------------------
  // link state is deliberately absent here so a loss holds the outputs
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SDFS_LOCK: state_nxt = SDFS_LOCK;
      SDFS_FAULT: if (!err_any) state_nxt = SDFS_OPEN;
      SDFS_OPEN: if (guard_closed) state_nxt = SDFS_ENABLED;
      SDFS_ENABLED: begin
        if (!guard_closed) state_nxt = SDFS_OPEN;
        else if (warn_any) state_nxt = SDFS_WARN;
      end
      SDFS_WARN: begin
        if (!guard_closed) state_nxt = SDFS_OPEN;
        else if (!warn_any) state_nxt = SDFS_ENABLED;
      end
      default: state_nxt = SDFS_LOCK;
    endcase
    if (lock_r) begin
      state_nxt = SDFS_LOCK;
    end else if (err_any) begin
      state_nxt = SDFS_FAULT;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SDFS_OPEN;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign chan_on = (state_r == SDFS_ENABLED) || (state_r == SDFS_WARN);

  // ----------------------------------------------------------------
  // safety outputs and indicators
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      safety_channel_a <= 1'b0;
      safety_channel_b <= 1'b0;
      diag_ok <= 1'b0;
      fault_led <= 1'b0;
    end else begin
      safety_channel_a <= chan_on;
      safety_channel_b <= chan_on;
      diag_ok <= (state_r == SDFS_ENABLED);
      fault_led <= (state_r == SDFS_FAULT) || (state_r == SDFS_LOCK) || warn_any;
    end
  end

  // ----------------------------------------------------------------
  // status bytes
  // ----------------------------------------------------------------
  // refreshed every cycle, all bits active high
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_response_byte <= `SDFS_BYTE_RST;
      warning_detail_byte <= `SDFS_BYTE_RST;
      error_detail_byte <= `SDFS_BYTE_RST;
    end else begin
      status_response_byte <= `SDFS_BYTE_RST;
      status_response_byte[`SDFS_RSP_OUT_ON] <= chan_on;
      status_response_byte[`SDFS_RSP_ACT] <= pin_s_r[`SDFS_PIN_ACT];
      status_response_byte[`SDFS_RSP_GUARD] <= pin_s_r[`SDFS_PIN_GA] & pin_s_r[`SDFS_PIN_GB];
      status_response_byte[`SDFS_RSP_DOOR] <= pin_s_r[`SDFS_PIN_DOOR];
      status_response_byte[`SDFS_RSP_WARN] <= warn_any && !lock_r && !err_any;
      status_response_byte[`SDFS_RSP_ERR] <= lock_r | err_any;
      warning_detail_byte <= `SDFS_BYTE_RST;
      warning_detail_byte[3:0] <= warn_cause;
      warning_detail_byte[`SDFS_DET_INT] <= pin_s_r[`SDFS_PIN_INT];
      warning_detail_byte[`SDFS_DET_COMM] <= link_fail;
      error_detail_byte <= `SDFS_BYTE_RST;
      error_detail_byte[3:0] <= err_out_r;
      error_detail_byte[`SDFS_DET_CROSS] <= err_out_r[`SDFS_DET_CROSS] | lock_r;
      error_detail_byte[`SDFS_DET_ACT] <= err_act_r;
      error_detail_byte[`SDFS_DET_INT] <= err_int_r;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chain_forward_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ##3 (serial_diag_chain_out == $past(serial_diag_chain_in, 3)))
    else $error("chain output does not follow input");

  internal_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pin_s_r[`SDFS_PIN_INT] |-> ##[1:4] (!safety_channel_a && !safety_channel_b))
    else $error("internal error left channels on");

  ack_clears_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (err_int_r && ack_fall && !pin_s_r[`SDFS_PIN_INT]) |=> !err_int_r)
    else $error("acknowledge did not clear internal error");

  out_err_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (|err_out_r && !guard_reclosed) |=> (err_out_r != 4'h0))
    else $error("output error cleared before next closing");

  lock_stays_a: assert property (@(posedge mclk) disable iff (!rst_n)
    lock_r |=> ##1 (lock_r && state_r == SDFS_LOCK && !safety_channel_a) [*2])
    else $error("lockout released without power cycle");

  warn_combo_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == SDFS_WARN) |=> (safety_channel_a && safety_channel_b && !diag_ok))
    else $error("warning output combination wrong");

  warn_autoclr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(warn_any) |=> !status_response_byte[`SDFS_RSP_WARN])
    else $error("warning flag stayed after cause left");

  escalate_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(warn_expired) |-> ##[1:4] (!safety_channel_a && fault_led))
    else $error("expired warning did not shut down");

  detail_shown_a: assert property (@(posedge mclk) disable iff (!rst_n)
    status_response_byte[`SDFS_RSP_ERR] |-> (error_detail_byte[5:0] != 6'h00))
    else $error("error flagged without detail");

  guard_bit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    status_response_byte[`SDFS_RSP_GUARD]
      == $past(pin_s_r[`SDFS_PIN_GA] & pin_s_r[`SDFS_PIN_GB]))
    else $error("guard bit does not match inputs");
endmodule // sdfs_supervisor

// file: hdl/sdfs_cfg.svh
// constants for the serial diagnostic fault supervisor
`ifndef SDFS_CFG_SVH
`define SDFS_CFG_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define SDFS_CLK_HZ 64'd25000000
`define SDFS_WARN_TIME_MIN 64'd30
`define SDFS_SEC_PER_MIN 64'd60
`define SDFS_WARN_CYCLES (`SDFS_WARN_TIME_MIN * `SDFS_SEC_PER_MIN * `SDFS_CLK_HZ)
`define SDFS_TIMER_W 40

// ----------------------------------------------------------------
// chain addressing
// ----------------------------------------------------------------
`define SDFS_MAX_NODES 5'd31
`define SDFS_MIN_NODE 5'd1

// ----------------------------------------------------------------
// request byte fields
// ----------------------------------------------------------------
`define SDFS_REQ_ACK 7

// ----------------------------------------------------------------
// response byte fields
// ----------------------------------------------------------------
`define SDFS_RSP_OUT_ON 0
`define SDFS_RSP_ACT 1
`define SDFS_RSP_GUARD 4
`define SDFS_RSP_DOOR 5
`define SDFS_RSP_WARN 6
`define SDFS_RSP_ERR 7

// ----------------------------------------------------------------
// detail byte fields (warning and error)
// ----------------------------------------------------------------
`define SDFS_DET_CH_A 0
`define SDFS_DET_CH_B 1
`define SDFS_DET_CROSS 2
`define SDFS_DET_TEMP 3
`define SDFS_DET_ACT 4
`define SDFS_DET_INT 5
`define SDFS_DET_COMM 6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SDFS_BYTE_RST 8'h00
`define SDFS_PINS_RST 12'h000
`define SDFS_CNT_RST 2'h0

// ----------------------------------------------------------------
// synchronised pin vector positions
// ----------------------------------------------------------------
`define SDFS_PIN_W 12
`define SDFS_PIN_GA 0
`define SDFS_PIN_GB 1
`define SDFS_PIN_ACT 2
`define SDFS_PIN_DOOR 3
`define SDFS_PIN_FA 4
`define SDFS_PIN_FB 5
`define SDFS_PIN_CROSS 6
`define SDFS_PIN_TEMP 7
`define SDFS_PIN_INT 8
`define SDFS_PIN_BADACT 9
`define SDFS_PIN_SHORT 10
`define SDFS_PIN_CHAIN 11

`endif

// file: hdl/sdfs_pkg.sv
// types for the serial diagnostic fault supervisor
package sdfs_pkg;
  // supervisor states, gray coded along open-enabled-warn-fault-lock
  typedef enum logic [2:0] {
    SDFS_OPEN = 3'h0,
    SDFS_ENABLED = 3'h1,
    SDFS_WARN = 3'h3,
    SDFS_FAULT = 3'h2,
    SDFS_LOCK = 3'h6
  } sdfs_state_e;
  typedef logic [7:0] sdfs_byte_t;
endpackage

// file: hdl/sdfs_warn_timer.sv
// persistence timer for an uninterrupted warning
`timescale 1ns/100ps
`include "sdfs_cfg.svh"
module sdfs_warn_timer import sdfs_pkg::*; #(
  parameter int CW = `SDFS_TIMER_W,
  parameter logic [CW-1:0] LIMIT = CW'(`SDFS_WARN_CYCLES)
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  output logic expired
);
  logic [CW-1:0] cnt_r;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (LIMIT == '0) begin
      $error("warning limit must be at least one cycle");
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // counts consecutive run cycles, restarts at any gap, saturates
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (!run) begin
      cnt_r <= '0;
    end else if (cnt_r != LIMIT) begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  assign expired = (cnt_r == LIMIT);

  // a gap in the warning always restarts the count
  gap_restart_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !run |=> !expired) else $error("timer expired without continuous warning");
endmodule // sdfs_warn_timer

// file: verif/sdfs_gw_model.sv
// gateway model that polls the chain with request bytes
`timescale 1ns/100ps
module sdfs_gw_model import sdfs_pkg::*; (
  input wire logic mclk,
  output logic req_valid,
  output logic [4:0] req_node,
  output sdfs_byte_t diag_request_byte,
  output logic link_fail
);
  // quiet bus at time zero
  initial begin
    req_valid = 1'b0;
    req_node = 5'h00;
    diag_request_byte = 8'h00;
    link_fail = 1'b0;
  end
  // one byte per request, valid for one sampling edge
  task automatic send(input logic [4:0] node, input sdfs_byte_t b);
    @(posedge mclk);
    #1;
    req_valid = 1'b1;
    req_node = node;
    diag_request_byte = b;
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
    req_node = ~node; // idle lines carry no stale value
    diag_request_byte = ~b;
  endtask
  // acknowledge: error reset bit set, then cleared
  task automatic ack(input logic [4:0] node);
    send(node, 8'h80);
    send(node, 8'h00);
  endtask
  // link loss level toward the node
  task automatic set_link(input logic v);
    @(posedge mclk);
    #1;
    link_fail = v;
  endtask
endmodule // sdfs_gw_model

// file: verif/tb.sv
// self-checking bench for the fault supervisor
`timescale 1ns/100ps
module tb import sdfs_pkg::*;;
  localparam logic [39:0] WARN_N = 40'h14;
  localparam logic [4:0] POS = 5'h07;
  logic mclk, rst_n, ga, gb, act, door, fa, fb, xs, ot, intf, bad, shrt, chin;
  logic req_valid, link_fail, chout, cha, chb, dok, led;
  logic [4:0] req_node;
  sdfs_byte_t req_byte, rsp, wdet, edet;
  int error_cnt = 0;
  int cmp_count = 0;
  // design with a short warning span
  sdfs_supervisor #(.WARN_CYCLES(WARN_N)) DUT (.mclk(mclk), .rst_n(rst_n),
    .node_position(POS), .guard_input_a(ga), .guard_input_b(gb),
    .actuator_present(act), .door_present(door), .fault_channel_a(fa),
    .fault_channel_b(fb), .cross_short(xs), .over_temp(ot), .internal_fault(intf),
    .actuator_invalid(bad), .channels_shorted(shrt), .serial_diag_chain_in(chin),
    .req_valid(req_valid), .req_node(req_node), .diag_request_byte(req_byte),
    .link_fail(link_fail), .serial_diag_chain_out(chout), .safety_channel_a(cha),
    .safety_channel_b(chb), .diag_ok(dok), .fault_led(led),
    .status_response_byte(rsp), .warning_detail_byte(wdet), .error_detail_byte(edet));
  // gateway on the far side
  sdfs_gw_model GW (.mclk(mclk), .req_valid(req_valid), .req_node(req_node),
    .diag_request_byte(req_byte), .link_fail(link_fail));
  // clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic guard(input logic v);
    ga = v;
    gb = v;
    act = v;
    door = v;
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    cyc(3);
    chk("outs_in_rst", {cha, chb, dok, led, chout}, 8'h00);
    rst_n = 1'b1;
    cyc(1);
    chk("rsp_rst", rsp, 8'h00);
    chk("det_rst", {wdet[3:0], edet[3:0]}, 8'h00);
  endtask
  task automatic t_chain();
    chin = 1'b1;
    cyc(2);
    chk("chain_early", chout, 8'h00);
    cyc(1);
    chk("chain_one", chout, 8'h01);
    chin = 1'b0;
    cyc(3);
    chk("chain_zero", chout, 8'h00);
  endtask
  task automatic t_enable();
    guard(1'b1);
    cyc(10);
    chk("rsp_on", rsp, 8'h33);
    chk("chan_on", {cha, chb, dok, led}, 8'h0e);
    door = 1'b0;
    cyc(4);
    chk("rsp_nodoor", rsp, 8'h13);
    door = 1'b1;
    cyc(4);
  endtask
  task automatic t_warn();
    ot = 1'b1;
    cyc(8);
    chk("rsp_warn", rsp, 8'h73);
    chk("wdet_temp", wdet, 8'h08);
    chk("warn_pins", {cha, chb, dok, led}, 8'h0d);
    ot = 1'b0;
    cyc(8);
    chk("rsp_nowarn", rsp, 8'h33);
    chk("wdet_clr", wdet, 8'h00);
    GW.set_link(1'b1);
    cyc(10);
    chk("link_chan", {cha, chb}, 8'h03);
    chk("wdet_link", wdet[6], 8'h01);
    GW.set_link(1'b0);
    cyc(4);
  endtask
  task automatic t_persist();
    xs = 1'b1;
    cyc(10);
    chk("early_chan", cha, 8'h01);
    cyc(25);
    chk("late_pins", {cha, chb, led}, 8'h01);
    chk("rsp_err", {rsp[7], rsp[0]}, 8'h02);
    chk("edet_cross", edet[2], 8'h01);
    xs = 1'b0;
    GW.ack(POS);
    cyc(8);
    chk("out_err_held", {rsp[7], cha}, 8'h02);
    guard(1'b0);
    cyc(6);
    guard(1'b1);
    cyc(10);
    chk("rsp_reenable", rsp, 8'h33);
  endtask
  task automatic t_internal();
    intf = 1'b1;
    cyc(7);
    chk("int_chan", {cha, chb}, 8'h00);
    chk("int_flags", {rsp[7], edet[5]}, 8'h03);
    chk("int_cause", wdet[5], 8'h01);
    GW.ack(POS);
    cyc(4);
    chk("ack_cause", rsp[7], 8'h01);
    intf = 1'b0;
    cyc(4);
    GW.ack(POS + 5'h01);
    cyc(4);
    chk("ack_other", rsp[7], 8'h01);
    GW.ack(POS);
    cyc(6);
    chk("ack_clear", {rsp[7], edet[5]}, 8'h00);
    intf = 1'b1;
    cyc(7);
    intf = 1'b0;
    guard(1'b0);
    cyc(8);
    chk("open_clear", rsp[7], 8'h00);
    bad = 1'b1;
    guard(1'b1);
    cyc(7);
    chk("bad_flags", {rsp[7], edet[4]}, 8'h03);
    bad = 1'b0;
    guard(1'b0);
    cyc(8);
    chk("bad_clear", {rsp[7], edet[4]}, 8'h00);
  endtask
  task automatic t_lock();
    guard(1'b1);
    fa = 1'b1;
    cyc(4);
    chk("wdet_fa", wdet, 8'h01);
    fa = 1'b0;
    cyc(4);
    fb = 1'b1;
    cyc(4);
    chk("wdet_fb", wdet[1], 8'h01);
    fb = 1'b0;
    cyc(4);
    cyc(4);
    chk("lock_two", {rsp[7], cha, chb}, 8'h04);
    GW.ack(POS);
    guard(1'b0);
    cyc(6);
    guard(1'b1);
    cyc(10);
    chk("lock_held", {rsp[7], cha}, 8'h02);
    do_reset();
    cyc(10);
    chk("lock_gone", rsp, 8'h33);
    shrt = 1'b1;
    cyc(3);
    shrt = 1'b0;
    cyc(8);
    chk("lock_short", {rsp[7], cha}, 8'h02);
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    complete_run();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    guard(1'b0);
    {fa, fb, xs, ot, intf, bad, shrt, chin} = 8'h00;
    do_reset();
    t_chain();
    t_enable();
    t_warn();
    t_persist();
    t_internal();
    t_lock();
    complete_run();
  end
endmodule // tb
